// *** hdl/dte_arb_if.sv ***
// request and grant lines between the engine and its channel arbiter
// assumes both ends run on the engine clock; purely combinational path
`timescale 1ns/10ps
interface dte_arb_if;
	logic [3:0] req;
	logic [1:0] mode;
	logic [1:0] last;
	logic [1:0] idx;
	logic       valid;
	modport eng (output req, output mode, output last, input idx, input valid);
	modport arb (input req, input mode, input last, output idx, output valid);
endinterface

// *** hdl/dte_arbiter.sv ***
// channel arbiter: fixed head of the list, round robin for the rest
// assumes last names the channel that moved data most recently
`timescale 1ns/10ps
module dte_arbiter (
	dte_arb_if.arb ab
);

	////////////////////////////////////////////////////////////////////////
	// pick one requesting channel
	always_comb begin
		logic [2:0] nfix;
		logic       found;
		logic [1:0] c;
		nfix = 3'h0;
		found = 1'b0;
		c = 2'h0;
		ab.idx = 2'h0;
		// channels below nfix are served in fixed order [R23]
		case (ab.mode)
			dte_pkg::PRI_RR:    nfix = 3'h0;
			dte_pkg::PRI_RR123: nfix = 3'h1;
			dte_pkg::PRI_RR23:  nfix = 3'h2;
			default:            nfix = 3'h4;
		endcase
		for (int i = 0; i < 4; i++) begin
			if (!found && (3'(i) < nfix) && ab.req[i]) begin
				found = 1'b1;
				ab.idx = 2'(i);
			end
		end
		// rotate from the one after last, so last ends lowest [R14]
		for (int j = 1; j <= 4; j++) begin
			c = ab.last + 2'(j);
			if (!found && ({1'b0, c} >= nfix) && ab.req[c]) begin
				found = 1'b1;
				ab.idx = c;
			end
		end
		ab.valid = found;
	end

endmodule // dte_arbiter

// *** hdl/dte_engine.sv ***
// four-channel dma transaction engine, top level with plain ports
// assumes a single-cycle byte bus: read data valid while the read address is out,
// and cpu_req from processor logic on the same clock
`timescale 1ns/10ps

// Overview of operation
// R1 - block length 1 byte to 64KB from the block count; zero means 64KB
// R2 - without double buffering, repeat runs the block once more before completion
// R3 - bursts are 1 or 2 bytes; bus held until the whole burst moved
// R4 - processor always wins; a burst starts only while cpu_req is low
// R5 - data moves only after a software, peripheral or event trigger per channel
// R6 - default trigger starts a block; channel disables itself after the transaction
// R7 - single-shot moves one burst per trigger; repeat block starts with no trigger
// R8 - one trigger kept pending during a transfer, further ones dropped
// R9 - peripheral channel address and direction come from the trigger source
// R10 - memory address static or incrementing; peripheral address steps only in 2-byte bursts
// R11 - addresses step each byte, reload at burst, block, transaction or never
// R12 - 2-byte peripheral burst touches low byte first then high byte
// R13 - counter reloads on transaction complete, never on error
// R14 - fixed or round robin arbitration; last mover gets lowest priority
// R15 - double buffer: clean finish enables the partner if its repeat bit set
// R16 - software never mixes double buffering and repeat; repeat is the link
// R17 - match on peripheral-to-memory channels, pattern in memory address, zero count free-runs
// R18 - match hit disables channel, flags completion, stores the matched byte
// R19 - counted scan with no hit disables, reloads count, flags error; no repeat
// R20 - search on standard channels, pattern in destination, source marks the hit
// R21 - error on eeprom write, eeprom read while off, or disable mid transfer
// R22 - controller and channel resets clear state only while disabled
// R23 - priority codes: full rr, ch0 then rr, ch0 ch1 then rr, fixed order
module dte_engine (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic             ctrl_enable,
	input  wire logic             ctrl_reset,
	input  wire logic [1:0]       double_buffer_select,
	input  wire logic [1:0]       priority_select,
	input  wire logic [3:0]       ch_enable_set,
	input  wire logic [3:0]       ch_enable_clr,
	input  wire logic [3:0]       ch_reset,
	input  wire logic [3:0]       ch_std,
	input  wire logic [3:0]       ch_single,
	input  wire logic [3:0]       ch_repeat,
	input  wire logic [3:0]       ch_burst2,
	input  wire logic [3:0]       ch_src_inc,
	input  wire logic [3:0]       ch_dst_inc,
	input  wire logic [3:0][1:0]  ch_src_reload,
	input  wire logic [3:0][1:0]  ch_dst_reload,
	input  wire logic [3:0][1:0]  ch_scan,
	input  wire logic [3:0][15:0] ch_blk_len,
	input  wire logic [3:0][15:0] ch_cfg_src,
	input  wire logic [3:0][15:0] ch_cfg_dst,
	input  wire logic [3:0][15:0] ch_per_addr,
	input  wire logic [3:0]       ch_per_to_mem,
	input  wire logic [3:0]       sw_trig,
	input  wire logic [3:0]       trig_pin,
	input  wire logic [3:0]       trn_clr,
	input  wire logic [3:0]       err_clr,
	input  wire logic             cpu_req,
	input  wire logic             eeprom_off,
	input  wire logic [7:0]       bus_rdata,
	output logic                  bus_req,
	output logic                  bus_we,
	output logic [15:0]           bus_addr,
	output logic [7:0]            bus_wdata,
	output logic [3:0]            st_en,
	output logic [3:0]            st_busy,
	output logic [3:0]            st_pend,
	output logic [3:0]            flag_trn,
	output logic [3:0]            flag_err,
	output logic [3:0][15:0]      ch_cnt,
	output logic [3:0][15:0]      ch_src,
	output logic [3:0][15:0]      ch_dst
);

	dte_pkg::dte_eng_t q;
	dte_pkg::dte_eng_t d;
	dte_arb_if         arb_bus ();

	////////////////////////////////////////////////////////////////////////
	// helpers

	// byte address of a read (rd=1) or write for a channel
	function automatic logic [15:0] addr_sel(
		input logic              rd,
		input dte_pkg::dte_chan_t c,
		input logic              std,
		input logic              p2m,
		input logic [15:0]       pa,
		input logic              bidx,
		input logic              b2
	);
		logic [15:0] pa_b;
		pa_b = pa + {15'h0000, b2 & bidx}; // low byte then high byte [R10] [R12]
		if (std)
			addr_sel = rd ? c.src : c.dst;
		else if (p2m == rd)
			addr_sel = pa_b; // peripheral side fixed by trigger source [R9]
		else
			addr_sel = c.src;
	endfunction

	function automatic logic in_ee(input logic [15:0] a);
		in_ee = (a >= dte_pkg::EE_BASE) && (a <= dte_pkg::EE_LAST);
	endfunction

	// match on peripheral-to-memory, search on standard channels [R17] [R20]
	function automatic logic is_scan(input logic [1:0] m, input logic std, input logic p2m);
		is_scan = (m != dte_pkg::SCAN_OFF) && (std || p2m);
	endfunction

	function automatic logic hit_fn(input logic [1:0] m, input logic [7:0] v,
		input logic [15:0] pat);
		case (m)
			dte_pkg::SCAN_EQ:   hit_fn = (v == pat[7:0]);
			dte_pkg::SCAN_MASK: hit_fn = ((v & pat[15:8]) == (pat[7:0] & pat[15:8]));
			dte_pkg::SCAN_OR:   hit_fn = (v == pat[7:0]) || (v == pat[15:8]);
			default:            hit_fn = 1'b0;
		endcase
	endfunction

	// {valid, index} of the chained partner
	function automatic logic [2:0] partner(input logic [1:0] db, input logic anystd,
		input logic [1:0] k);
		case (db)
			dte_pkg::DB_01:  partner = {~k[1], k ^ 2'h1};
			dte_pkg::DB_23:  partner = {k[1], k ^ 2'h1};
			dte_pkg::DB_ALL: partner = anystd ? {~k[0], k ^ 2'h2} : {1'b1, k ^ 2'h1};
			default:         partner = 3'h0;
		endcase
	endfunction

	// software enable: fresh count and addresses
	function automatic dte_pkg::dte_chan_t ch_load(input dte_pkg::dte_chan_t c,
		input logic [15:0] len, input logic [15:0] s, input logic [15:0] t);
		ch_load          = c;
		ch_load.en       = 1'b1;
		ch_load.cnt      = len;
		ch_load.src      = s;
		ch_load.dst      = t;
		ch_load.rep_done = 1'b0;
	endfunction

	// channel off: no enable, busy, active or pending
	function automatic dte_pkg::dte_chan_t ch_stop(input dte_pkg::dte_chan_t c);
		ch_stop        = c;
		ch_stop.en     = 1'b0;
		ch_stop.busy   = 1'b0;
		ch_stop.active = 1'b0;
		ch_stop.pend   = 1'b0;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// arbitration between ready channels
	always_comb begin
		for (int i = 0; i < 4; i++)
			arb_bus.req[i] = q.ch[i].en & q.ch[i].active & ctrl_enable;
	end
	assign arb_bus.mode = priority_select;
	assign arb_bus.last = q.last;

	dte_arbiter u_arb (
		.ab (arb_bus)
	);

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [3:0]  trig;
		logic [1:0]  k;
		logic [1:0]  p;
		logic [2:0]  pp;
		logic [15:0] wa;
		logic        scan;
		logic        fin;
		logic        hit;
		logic        err;
		logic        free;
		logic        lastblk;
		logic        bdone;
		logic        txend;
		logic        b2;
		trig = 4'h0;
		k = q.cur;
		p = 2'h0;
		pp = 3'h0;
		wa = 16'h0000;
		fin = 1'b0;
		hit = 1'b0;
		err = 1'b0;
		free = 1'b0;
		lastblk = 1'b0;
		bdone = 1'b0;
		txend = 1'b0;
		d = q;

		// pin triggers pass two flops, edge taken after the second
		d.s1 = trig_pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.ena_prev = ctrl_enable;
		trig = sw_trig | (q.s2 & ~q.s3);

		// software side of each channel; flag sets below override these clears
		for (int i = 0; i < 4; i++) begin
			if (trn_clr[i])
				d.ch[i].trnif = 1'b0;
			if (err_clr[i])
				d.ch[i].errif = 1'b0;
			if (ch_enable_set[i] && !q.ch[i].en)
				d.ch[i] = ch_load(d.ch[i], ch_blk_len[i], ch_cfg_src[i], ch_cfg_dst[i]);
			if ((ch_enable_clr[i] || (q.ena_prev && !ctrl_enable)) && q.ch[i].en) begin
				d.ch[i].errif  = d.ch[i].errif | q.ch[i].busy; // [R21]
				d.ch[i] = ch_stop(d.ch[i]);
			end
			if (trig[i] && d.ch[i].en) begin
				if (!d.ch[i].active) begin
					d.ch[i].active = 1'b1; // [R5]
					d.ch[i].busy   = 1'b1;
				end else
					d.ch[i].pend = 1'b1; // kept pending; any further one is simply lost [R8]
			end
		end

		scan = is_scan(ch_scan[k], ch_std[k], ch_per_to_mem[k]);
		b2 = ch_burst2[k];
		pp = partner(double_buffer_select, ch_std[0] | ch_std[2], k);
		p = pp[1:0];

		// byte mover
		case (q.st)
			dte_pkg::ST_IDLE: begin
				d.bus_req = 1'b0;
				d.bus_we = 1'b0;
				// the processor goes first, the burst waits [R4] [R14]
				if (arb_bus.valid && !cpu_req) begin
					d.cur = arb_bus.idx;
					d.bidx = 1'b0;
					d.st = dte_pkg::ST_RD;
					d.bus_req = 1'b1; // held to the end of the burst [R3]
					d.bus_addr = addr_sel(1'b1, q.ch[arb_bus.idx], ch_std[arb_bus.idx],
						ch_per_to_mem[arb_bus.idx], ch_per_addr[arb_bus.idx], 1'b0,
						ch_burst2[arb_bus.idx]);
				end
			end
			dte_pkg::ST_RD: begin
				wa = addr_sel(1'b0, q.ch[k], ch_std[k], ch_per_to_mem[k], ch_per_addr[k],
					q.bidx, b2);
				if (in_ee(q.bus_addr) && eeprom_off)
					err = 1'b1; // [R21]
				else if (scan) begin
					fin = 1'b1;
					// scan reads only; misses are never written [R17] [R18]
					hit = hit_fn(ch_scan[k], bus_rdata, ch_std[k] ? q.ch[k].dst : q.ch[k].src);
				end else if (in_ee(wa))
					err = 1'b1; // eeprom is never written [R21]
				else begin
					d.st = dte_pkg::ST_WR;
					d.bus_we = 1'b1;
					d.bus_addr = wa;
					d.bus_wdata = bus_rdata;
				end
			end
			dte_pkg::ST_WR: begin
				d.bus_we = 1'b0;
				fin = 1'b1;
			end
			default: d.st = dte_pkg::ST_IDLE;
		endcase

		if (err) begin
			// no count reload on error [R13]
			d.ch[k] = ch_stop(d.ch[k]);
			d.ch[k].errif = 1'b1;
			d.st = dte_pkg::ST_IDLE;
			d.bus_req = 1'b0;
			d.bus_we = 1'b0;
			d.last = k;
		end else if (fin && hit) begin
			// matched byte replaces the pattern low byte, source stays on it [R18] [R20]
			if (ch_std[k])
				d.ch[k].dst[7:0] = bus_rdata;
			else
				d.ch[k].src[7:0] = bus_rdata;
			d.ch[k] = ch_stop(d.ch[k]);
			d.ch[k].trnif = 1'b1;
			d.ch[k].rep_done = 1'b0;
			d.ch[k].cnt = ch_blk_len[k]; // [R13]
			d.st = dte_pkg::ST_IDLE;
			d.bus_req = 1'b0;
			d.last = k;
		end else if (fin) begin
			// step after each byte; pattern registers never step [R10] [R11]
			if (ch_src_inc[k] && (ch_std[k] || !scan))
				d.ch[k].src = d.ch[k].src + 16'h0001;
			if (ch_std[k] && ch_dst_inc[k] && !scan)
				d.ch[k].dst = d.ch[k].dst + 16'h0001;
			// zero count: free-running scan, else 64KB block [R1] [R17]
			free = scan && (ch_blk_len[k] == 16'h0000);
			lastblk = !free && (d.ch[k].cnt == 16'h0001);
			if (!free)
				d.ch[k].cnt = d.ch[k].cnt - 16'h0001;
			bdone = lastblk || !b2 || q.bidx;
			// no repeat in scan; repeat is the chain link under double buffering [R16] [R19]
			txend = lastblk && !scan && !(ch_repeat[k] && !pp[2] && !d.ch[k].rep_done);
			if (!bdone) begin
				d.bidx = 1'b1; // second byte, bus kept [R3]
				d.st = dte_pkg::ST_RD;
				d.bus_addr = addr_sel(1'b1, d.ch[k], ch_std[k], ch_per_to_mem[k],
					ch_per_addr[k], 1'b1, b2);
			end else begin
				d.st = dte_pkg::ST_IDLE;
				d.bus_req = 1'b0;
				d.last = k;
				// original addresses back at the chosen point [R11]
				if ((ch_src_reload[k] == dte_pkg::RL_BURST) ||
					(lastblk && ch_src_reload[k] == dte_pkg::RL_BLOCK) ||
					(txend && ch_src_reload[k] == dte_pkg::RL_TRANS))
					d.ch[k].src = ch_cfg_src[k];
				if ((ch_dst_reload[k] == dte_pkg::RL_BURST) ||
					(lastblk && ch_dst_reload[k] == dte_pkg::RL_BLOCK) ||
					(txend && ch_dst_reload[k] == dte_pkg::RL_TRANS))
					d.ch[k].dst = ch_cfg_dst[k];
				if (lastblk) begin
					d.ch[k].cnt = ch_blk_len[k]; // [R13] [R19]
					if (scan) begin
						d.ch[k] = ch_stop(d.ch[k]); // counted scan ran out [R19]
						d.ch[k].errif = 1'b1;
					end else if (!txend) begin
						d.ch[k].rep_done = 1'b1; // [R2]
						d.ch[k].active = ch_single[k]; // [R6] [R7]
					end else begin
						d.ch[k] = ch_stop(d.ch[k]); // [R6]
						d.ch[k].trnif = 1'b1;
						d.ch[k].rep_done = 1'b0;
						// clean finish hands over to the partner [R15]
						if (pp[2] && ch_repeat[p] && !d.ch[p].en)
							d.ch[p] = ch_load(d.ch[p], ch_blk_len[p], ch_cfg_src[p],
								ch_cfg_dst[p]);
					end
				end else if (ch_single[k])
					d.ch[k].active = 1'b0; // one burst per trigger [R7]
				if (d.ch[k].en && !d.ch[k].active && d.ch[k].pend) begin
					d.ch[k].active = 1'b1; // pending trigger served now [R8]
					d.ch[k].pend = 1'b0;
				end
			end
		end

		// a disabled channel or controller drops the burst at once
		if ((d.st != dte_pkg::ST_IDLE) && (!d.ch[d.cur].en || !ctrl_enable)) begin
			d.st = dte_pkg::ST_IDLE;
			d.bus_req = 1'b0;
			d.bus_we = 1'b0;
		end

		// software resets, honoured only while disabled [R22]
		for (int i = 0; i < 4; i++) begin
			if (ch_reset[i] && !q.ch[i].en)
				d.ch[i] = '0;
		end
		if (ctrl_reset && !ctrl_enable)
			d = dte_pkg::ENG_RST;
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clock) begin
		if (!rst_b)
			q <= dte_pkg::ENG_RST;
		else
			q <= d;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign bus_req   = q.bus_req;
	assign bus_we    = q.bus_we;
	assign bus_addr  = q.bus_addr;
	assign bus_wdata = q.bus_wdata;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			st_en[i]    = q.ch[i].en;
			st_busy[i]  = q.ch[i].busy;
			st_pend[i]  = q.ch[i].pend;
			flag_trn[i] = q.ch[i].trnif;
			flag_err[i] = q.ch[i].errif;
			ch_cnt[i]   = q.ch[i].cnt;
			ch_src[i]   = q.ch[i].src;
			ch_dst[i]   = q.ch[i].dst;
		end
	end

endmodule // dte_engine

// *** hdl/dte_pkg.sv ***
// shared constants and types of the dma transaction engine
// assumes four channels and a 16-bit byte address space shared with the processor
package dte_pkg;

	localparam int          NCH       = 4;

	// eeprom window in the data space; placement is a free choice of this block
	localparam logic [15:0] EE_BASE   = 16'h1000;
	localparam logic [15:0] EE_LAST   = 16'h1FFF;

	// address reload points
	localparam logic [1:0]  RL_NEVER  = 2'h0;
	localparam logic [1:0]  RL_BURST  = 2'h1;
	localparam logic [1:0]  RL_BLOCK  = 2'h2;
	localparam logic [1:0]  RL_TRANS  = 2'h3;

	// match / search compare modes
	localparam logic [1:0]  SCAN_OFF  = 2'h0;
	localparam logic [1:0]  SCAN_EQ   = 2'h1;
	localparam logic [1:0]  SCAN_MASK = 2'h2;
	localparam logic [1:0]  SCAN_OR   = 2'h3;

	// priority_select codes
	localparam logic [1:0]  PRI_RR    = 2'h0;
	localparam logic [1:0]  PRI_RR123 = 2'h1;
	localparam logic [1:0]  PRI_RR23  = 2'h2;
	localparam logic [1:0]  PRI_FIXED = 2'h3;

	// double_buffer_select codes
	localparam logic [1:0]  DB_OFF    = 2'h0;
	localparam logic [1:0]  DB_01     = 2'h1;
	localparam logic [1:0]  DB_23     = 2'h2;
	localparam logic [1:0]  DB_ALL    = 2'h3;

	typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} dte_state_t;

	typedef struct packed {
		logic        en;
		logic        busy;
		logic        active;
		logic        pend;
		logic        trnif;
		logic        errif;
		logic        rep_done;
		logic [15:0] cnt;
		logic [15:0] src;
		logic [15:0] dst;
	} dte_chan_t;

	typedef struct packed {
		dte_chan_t [3:0] ch;
		dte_state_t      st;
		logic [1:0]      cur;
		logic [1:0]      last;
		logic            bidx;
		logic [3:0]      s1;
		logic [3:0]      s2;
		logic [3:0]      s3;
		logic            ena_prev;
		logic            bus_req;
		logic            bus_we;
		logic [15:0]     bus_addr;
		logic [7:0]      bus_wdata;
	} dte_eng_t;

	localparam dte_eng_t ENG_RST = '0;

endpackage

// *** verification/dte_bus_model.sv ***
// byte memory and peripheral space on the shared data bus
// assumes the engine samples read data in the cycle its read address is out
`timescale 1ns/10ps
module dte_bus_model (
	input  logic        clock,
	input  logic        bus_req,
	input  logic        bus_we,
	input  logic [15:0] bus_addr,
	input  logic [7:0]  bus_wdata,
	output logic [7:0]  bus_rdata
);
	logic [7:0] mem [0:255];
	logic [7:0] last_q;

	// every byte differs from its neighbours; only 8 address bits decoded
	initial begin
		last_q = 8'hA5;
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5A;
		end
	end

	// released bus shows a changing pattern, never a stale copy
	assign bus_rdata = (bus_req && !bus_we) ? mem[bus_addr[7:0]] : ~last_q;

	// one byte per write cycle, landing at its closing edge
	always @(posedge clock) begin
		if (bus_req && bus_we) begin
			mem[bus_addr[7:0]] <= bus_wdata;
		end
		last_q <= bus_rdata;
	end
endmodule // dte_bus_model

// *** verification/dte_engine_sva.sv ***
// port-level checks for the dma transaction engine
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/10ps
module dte_engine_sva (
	input logic             clock,
	input logic             rst_b,
	input logic             ctrl_enable,
	input logic             ctrl_reset,
	input logic [3:0]       ch_enable_clr,
	input logic [3:0]       ch_reset,
	input logic [3:0][15:0] ch_blk_len,
	input logic             cpu_req,
	input logic             eeprom_off,
	input logic [7:0]       bus_rdata,
	input logic             bus_req,
	input logic             bus_we,
	input logic [15:0]      bus_addr,
	input logic [7:0]       bus_wdata,
	input logic [3:0]       st_en,
	input logic [3:0]       st_busy,
	input logic [3:0]       flag_trn,
	input logic [3:0]       flag_err,
	input logic [3:0][15:0] ch_cnt,
	input logic [3:0][15:0] ch_src
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	logic in_ee;

	// address falls in the eeprom window
	assign in_ee = bus_addr >= dte_pkg::EE_BASE && bus_addr <= dte_pkg::EE_LAST;

	////////////////////////////////////////
	// bus sequencing
	chk_start_no_cpu: assert property ($rose(bus_req) |-> !bus_we && !$past(cpu_req))
		else $error("burst start ignored cpu");
	chk_start_busy: assert property ($rose(bus_req) |-> $past(st_busy) != 4'h0)
		else $error("bus taken untriggered");
	chk_burst_len: assert property ($rose(bus_req) |-> ##[1:4] !bus_req)
		else $error("burst too long");
	chk_write_copy: assert property (bus_we |-> bus_req && $past(bus_req) && !$past(bus_we)
		&& bus_wdata == $past(bus_rdata))
		else $error("write data not from read");

	////////////////////////////////////////
	// errors
	chk_no_ee_write: assert property (bus_we |-> !in_ee)
		else $error("eeprom write");
	chk_ee_off_read: assert property (bus_req && !bus_we && eeprom_off && in_ee
		|-> ##1 !bus_we ##[0:1] flag_err != 4'h0)
		else $error("read of sleeping eeprom not refused");
	chk_clr_busy_err: assert property (ch_enable_clr[0] && st_busy[0]
		|=> !st_en[0] && flag_err[0])
		else $error("busy disable missed error");
	chk_ctrl_abort: assert property ($fell(ctrl_enable)
		|=> (flag_err & $past(st_busy)) == $past(st_busy))
		else $error("ctrl disable missed error");

	////////////////////////////////////////
	// completion and resets
	chk_trn_reload: assert property ($rose(flag_trn[0])
		|-> ch_cnt[0] == ch_blk_len[0] && !st_busy[0])
		else $error("counter not reloaded or busy at completion");
	chk_chan_reset: assert property (ch_reset[0] && !st_en[0]
		|=> ch_cnt[0] == 16'h0000 && ch_src[0] == 16'h0000)
		else $error("chan reset incomplete");
	chk_ctrl_reset: assert property (ctrl_reset && !ctrl_enable
		|=> !bus_req && st_en == 4'h0 && flag_err == 4'h0 && flag_trn == 4'h0)
		else $error("ctrl reset incomplete");

	// main scenarios reached
	cov_two_byte: cover property (bus_req [*4]);
	cov_error: cover property ($rose(flag_err[0]));
	cov_match: cover property ($rose(flag_trn[2]));
endmodule // dte_engine_sva

bind dte_engine dte_engine_sva u_sva (.*);

// *** verification/tb.sv ***
// self-checking bench for the dma transaction engine
// assumes the bus model as memory; inputs change at the falling edge
`timescale 1ns/10ps
module tb;
	logic             clock, rst_b, ctrl_enable, ctrl_reset, cpu_req, eeprom_off;
	logic [1:0]       double_buffer_select, priority_select;
	logic [3:0]       ch_enable_set, ch_enable_clr, ch_reset, ch_std, ch_single, ch_repeat;
	logic [3:0]       ch_burst2, ch_src_inc, ch_dst_inc, ch_per_to_mem, sw_trig, trig_pin;
	logic [3:0]       trn_clr, err_clr, st_en, st_busy, st_pend, flag_trn, flag_err;
	logic [3:0][1:0]  ch_src_reload, ch_dst_reload, ch_scan;
	logic [3:0][15:0] ch_blk_len, ch_cfg_src, ch_cfg_dst, ch_per_addr, ch_cnt, ch_src, ch_dst;
	logic             bus_req, bus_we, got_first;
	logic [15:0]      bus_addr, first_a;
	logic [7:0]       bus_rdata, bus_wdata;
	int               failures, num_checks, wr_n;

	dte_engine dut (.*);
	dte_bus_model u_mem (.*);

	// 40 MHz clock
	initial begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end

	// count written bytes and note the first read address of a race; settled at negedge
	always @(negedge clock) begin
		if (bus_req && bus_we) wr_n++;
		if (bus_req && !bus_we && !got_first) begin
			first_a = bus_addr;
			got_first = 1;
		end
	end

	////////////////////////////////////////
	function automatic logic [7:0] pat(input logic [7:0] a);
		return a ^ 8'h5A;
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic close_out();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	// defaults; disabling idle channels here raises no error
	task automatic clean();
		@(negedge clock);
		{ch_single, ch_repeat, ch_burst2, ch_per_to_mem} = '0;
		{ch_scan, ch_src_reload, ch_dst_reload} = '0;
		{ch_src_inc, ch_dst_inc} = '1;
		double_buffer_select = dte_pkg::DB_OFF;
		priority_select = dte_pkg::PRI_FIXED;
		ch_enable_clr = '1;
		tick(1);
		ch_enable_clr = '0;
	endtask
	// program and enable one channel, clearing its old flags
	task automatic prog(input int i, input logic s, input logic [15:0] n, a, d);
		ch_std[i] = s;
		ch_blk_len[i] = n;
		ch_cfg_src[i] = a;
		ch_cfg_dst[i] = d;
		{ch_enable_set[i], trn_clr[i], err_clr[i]} = 3'h7;
		tick(1);
		{ch_enable_set[i], trn_clr[i], err_clr[i]} = 3'h0;
	endtask
	task automatic trig(input int i);
		sw_trig[i] = 1;
		tick(1);
		sw_trig[i] = 0;
	endtask
	task automatic wait_done(input int i);
		int k;
		for (k = 0; k < 600 && flag_trn[i] !== 1'b1 && flag_err[i] !== 1'b1; k++) tick(1);
		if (k == 600) begin
			failures++;
			close_out();
		end
	endtask

	////////////////////////////////////////
	task automatic t_copy();
		clean();
		prog(0, 1, 16'h0003, 16'h0010, 16'h0040);
		cpu_req = 1;
		trig(0);
		tick(6);
		chk(bus_req, 0);
		cpu_req = 0;
		wait_done(0);
		for (int j = 0; j < 3; j++) chk(u_mem.mem[8'h40 + j], pat(8'h10 + j));
		chk(st_en[0], 0);
		chk(ch_cnt[0], 16'h0003);
	endtask
	task automatic t_single();
		clean();
		{ch_single[0], ch_burst2[0]} = 2'h3;
		ch_dst_reload[0] = dte_pkg::RL_BURST;
		prog(0, 1, 16'h0006, 16'h0020, 16'h0060);
		wr_n = 0;
		trig(0);
		trig(0);
		trig(0);
		chk(st_pend[0], 1);
		tick(30);
		chk(16'(wr_n), 16'h0004);
		chk(ch_cnt[0], 16'h0002);
		chk(ch_src[0], 16'h0024);
		chk(ch_dst[0], 16'h0060);
		trig(0);
		wait_done(0);
		chk(flag_trn[0], 1);
	endtask
	task automatic t_repeat();
		clean();
		ch_repeat[0] = 1;
		prog(0, 1, 16'h0001, 16'h0030, 16'h00B0);
		trig(0);
		tick(12);
		chk(flag_trn[0], 0);
		trig(0);
		wait_done(0);
		chk(u_mem.mem[8'hB1], pat(8'h31));
	endtask
	task automatic t_per();
		clean();
		ch_burst2[1] = 1;
		ch_per_addr[1] = 16'h0080;
		prog(1, 0, 16'h0002, 16'h0030, 16'h0000);
		trig_pin[1] = 1;
		wait_done(1);
		trig_pin[1] = 0;
		chk(u_mem.mem[8'h80], pat(8'h30));
		chk(u_mem.mem[8'h81], pat(8'h31));
	endtask
	task automatic t_match();
		logic [15:0] p [3] = '{16'h0069, 16'hFF69, 16'h6911};
		for (int m = 0; m < 3; m++) begin
			clean();
			{ch_per_to_mem[2], ch_src_inc[2]} = 2'h2;
			ch_scan[2] = 2'(m + 1);
			ch_per_addr[2] = 16'h0033;
			prog(2, 0, 16'h0000, p[m], 16'h0000);
			trig(2);
			wait_done(2);
			chk(flag_trn[2], 1);
			chk(st_en[2], 0);
			chk(ch_src[2][7:0], 8'h69);
		end
		prog(2, 0, 16'h0003, 16'h0011, 16'h0000);
		trig(2);
		wait_done(2);
		chk(flag_err[2], 1);
		chk(ch_cnt[2], 16'h0003);
	endtask
	task automatic t_search();
		clean();
		ch_scan[0] = dte_pkg::SCAN_EQ;
		prog(0, 1, 16'h0008, 16'h0010, 16'h0049);
		trig(0);
		wait_done(0);
		chk(flag_trn[0], 1);
		chk(ch_src[0], 16'h0013);
	endtask
	task automatic t_eeprom();
		clean();
		prog(0, 1, 16'h0002, 16'h0010, 16'h0FFF);
		trig(0);
		wait_done(0);
		chk(flag_err[0], 1);
		chk(ch_cnt[0], 16'h0001);
		chk(u_mem.mem[8'h00], pat(8'h00));
		eeprom_off = 1;
		prog(0, 1, 16'h0001, 16'h1005, 16'h0070);
		trig(0);
		wait_done(0);
		chk(flag_err[0], 1);
		eeprom_off = 0;
	endtask
	task automatic t_abort();
		clean();
		prog(0, 1, 16'h00C8, 16'h0010, 16'h0090);
		prog(1, 1, 16'h00C8, 16'h0010, 16'h0090);
		trig(0);
		trig(1);
		tick(8);
		ch_enable_clr[0] = 1;
		tick(1);
		ch_enable_clr[0] = 0;
		chk(flag_err[0], 1);
		ch_reset[0] = 1;
		tick(1);
		ch_reset[0] = 0;
		chk(ch_cnt[0], 16'h0000);
		tick(8);
		ctrl_enable = 0;
		tick(2);
		chk(flag_err[1], 1);
		ctrl_reset = 1;
		tick(1);
		ctrl_reset = 0;
		chk(flag_err, 4'h0);
		ctrl_enable = 1;
	endtask
	task automatic t_dbuf();
		for (int r = 0; r < 2; r++) begin
			clean();
			double_buffer_select = dte_pkg::DB_01;
			ch_repeat[1] = r[0]; // link bit only on the second channel
			prog(0, 1, 16'h0001, 16'h0010, 16'h00A0);
			trig(0);
			wait_done(0);
			tick(2);
			chk(st_en[1], r[0]);
		end
	endtask
	// ch0 alone, then ch0 and ch1 race per priority code
	task automatic t_prio();
		logic [15:0] e [4] = '{16'h0060, 16'h0050, 16'h0050, 16'h0050};
		for (int p = 0; p < 4; p++) begin
			clean();
			priority_select = 2'(p);
			prog(0, 1, 16'h0001, 16'h0050, 16'h00C0);
			trig(0);
			wait_done(0);
			prog(0, 1, 16'h0001, 16'h0050, 16'h00C0);
			prog(1, 1, 16'h0001, 16'h0060, 16'h00C1);
			got_first = 0;
			sw_trig = 4'h3;
			tick(1);
			sw_trig = 4'h0;
			wait_done(1);
			wait_done(0);
			chk(first_a, e[p]);
		end
	endtask

	////////////////////////////////////////
	// main sequence
	initial begin
		{ctrl_enable, ctrl_reset, cpu_req, eeprom_off, ch_enable_set, ch_enable_clr} = '0;
		{ch_reset, sw_trig, trig_pin, trn_clr, err_clr, ch_std, ch_single, ch_repeat} = '0;
		{ch_burst2, ch_src_inc, ch_dst_inc, ch_per_to_mem, ch_scan, ch_src_reload} = '0;
		{ch_dst_reload, ch_blk_len, ch_cfg_src, ch_cfg_dst, ch_per_addr} = '0;
		{double_buffer_select, priority_select, failures, num_checks, wr_n, got_first} = '0;
		rst_b = 0;
		tick(10);
		rst_b = 1;
		ctrl_enable = 1;
		t_copy();
		t_single();
		t_repeat();
		t_per();
		t_match();
		t_search();
		t_eeprom();
		t_abort();
		t_dbuf();
		t_prio();
		close_out();
	end
endmodule // tb
